// ### include/cbm_pkg.sv
// Constants for the configurable pin multiplexer and bit-bang port.
// Assumes a 250 MHz system clock and a 32-bit classic Wishbone register bus.
package cbm_pkg;
	// Pin function codes, five bits per pin
	localparam logic [4:0] FN_TRI   = 5'h00;
	localparam logic [4:0] FN_ONE   = 5'h01;
	localparam logic [4:0] FN_ZERO  = 5'h02;
	localparam logic [4:0] FN_LDEN  = 5'h03;
	localparam logic [4:0] FN_PSW   = 5'h04;
	localparam logic [4:0] FN_TXLED = 5'h05;
	localparam logic [4:0] FN_RXLED = 5'h06;
	localparam logic [4:0] FN_ANLED = 5'h07;
	localparam logic [4:0] FN_SLEEP = 5'h08;
	localparam logic [4:0] FN_CKF   = 5'h09;
	localparam logic [4:0] FN_CKM   = 5'h0A;
	localparam logic [4:0] FN_CKS   = 5'h0B;
	localparam logic [4:0] FN_GPIO  = 5'h0C;
	localparam logic [4:0] FN_CHG   = 5'h0D;
	localparam logic [4:0] FN_CHGN  = 5'h0E;
	localparam logic [4:0] FN_WRS   = 5'h0F;
	localparam logic [4:0] FN_RDS   = 5'h10;
	localparam logic [4:0] FN_VBUS  = 5'h11;
	localparam logic [4:0] FN_SOF   = 5'h12;
	localparam logic [4:0] FN_AWAKE = 5'h13;

	// Register byte offsets
	localparam logic [7:0] ADR_SEL  = 8'h00;
	localparam logic [7:0] ADR_MODE = 8'h04;
	localparam logic [7:0] ADR_PRE  = 8'h08;
	localparam logic [7:0] ADR_GPIO = 8'h0C;
	localparam logic [7:0] ADR_DATA = 8'h10;
	localparam logic [7:0] ADR_DIR  = 8'h14;
	localparam logic [7:0] ADR_STAT = 8'h18;

	// Reset values: pins 0..3 = line driver enable, rx led, tx led, sleep
	localparam logic [19:0] SEL_RST = 20'h414C3;
	localparam logic [1:0]  MODE_RST = 2'h0;
	localparam logic [13:0] PRE_RST = 14'h0010;

	// Bit-bang modes
	localparam logic [1:0] MD_ASYNC = 2'h1;
	localparam logic [1:0] MD_SYNC  = 2'h2;

	// Timing
	localparam longint CLK_HZ  = 250_000_000;
	localparam longint FAST_HZ = 24_000_000;
	localparam logic [31:0] NCO_INC = 32'((FAST_HZ << 32) / CLK_HZ);
	localparam int STB_NS  = 16;
	localparam logic [13:0] STB_CYC = 14'((STB_NS * 250 + 999) / 1000);
	localparam int LED_NS  = 1000;
	localparam logic [7:0] LED_CYC = 8'((LED_NS * 250) / 1000);

	typedef enum logic [1:0] {
		BB_IDLE = 2'b00,
		BB_RD   = 2'b01,
		BB_WR   = 2'b11,
		BB_PACE = 2'b10
	} cbm_bb_t;
endpackage : cbm_pkg

// ### verilog/cbm_top.sv
// Configurable pin multiplexer with bit-bang port and Wishbone registers.
// Assumes the USB core gives one-cycle event pulses and levels on clk_i.
// How it works
// RULE1: sleep pin low while link suspended
// RULE2: clock pins run 24/12/6 MHz, stop suspended
// RULE3: each pin may be register-driven GPIO
// RULE4: charger pin high when charger detected
// RULE5: inverted charger pin is exact complement
// RULE6: strobe pins carry internal port strobes
// RULE7: sense pin input decides bus power
// RULE8: frame pin toggles per start-of-frame
// RULE9: low keep-awake input blocks suspend
// RULE10: one function per pin from selection
// RULE11: bit-bang turns UART lines into port
// RULE12: async bytes applied, paced by prescaler
// RULE13: strobes pulse on every port access; sync-mode reads give no strobe here
// RULE14: sync mode samples pins only on write
// RULE15: tristate, constant one, constant zero options
// RULE16: activity pins pulse low on traffic
// RULE17: frame low, no charger after reset
`timescale 1ns/1ps
module cbm_top
	import cbm_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic [31:0]      wb_dat_o,
	// USB core
	input  wire logic        usb_susp_req_i,
	input  wire logic        usb_sof_i,
	input  wire logic        usb_tx_act_i,
	input  wire logic        usb_rx_act_i,
	input  wire logic        usb_cfg_i,
	input  wire logic        chg_det_i,
	input  wire logic        chg_done_i,
	input  wire logic        line_driver_enable_i,
	output logic             usb_suspend_o,
	output logic             bus_power_sense_o,
	// UART side
	input  wire logic [7:0]  uart_out_i,
	input  wire logic [7:0]  uart_oe_i,
	output logic [7:0]       uart_in_o,
	// Eight port pins
	input  wire logic [7:0]  port_i,
	output logic [7:0]       port_o,
	output logic [7:0]       port_oe_o,
	// Four configurable pins
	input  wire logic [3:0]  config_pin_group_i,
	output logic [3:0]       config_pin_group_o,
	output logic [3:0]       config_pin_group_oe_o
);
	logic [7:0]  port_m_r, port_s_r;
	logic [3:0]  cpg_m_r, cpg_s_r;
	logic [19:0] sel_r;
	logic [1:0]  mode_r;
	logic [13:0] pre_r;
	logic [3:0]  gpo_r, gpoe_r;
	logic [7:0]  dout_r, drive_r, dir_r, samp_r;
	logic        susp_r, sof_r, ack_r, wr_pend_r;
	logic        port_write_strobe_n_r, port_read_strobe_n_r;
	logic [31:0] nco_r, rdat_r;
	logic        ckf_d_r, ckm_r, ckm_d_r, cks_r;
	logic [7:0]  txl_r, rxl_r;
	logic [13:0] cnt_r, cnt_nxt;
	cbm_bb_t     st_r, st_nxt;
	logic [3:0]  pin_nxt, oe_nxt;
	logic        vbus, inhibit;

	// Pins come from outside the clock domain
	always_ff @(posedge clk_i) begin
		port_m_r <= port_i;
		port_s_r <= port_m_r;
		cpg_m_r  <= config_pin_group_i;
		cpg_s_r  <= cpg_m_r;
	end

	// Bus decode
	wire        req     = wb_cyc_i & wb_stb_i & ~ack_r;
	wire        bb_on   = (mode_r == MD_ASYNC) | (mode_r == MD_SYNC);
	wire        a_dat   = wb_adr_i == ADR_DATA;
	wire        hold    = a_dat & bb_on & (st_r != BB_IDLE);
	wire        go      = req & ~hold;
	wire        wen     = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
	wire [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire        go_wdat = go & wb_we_i & a_dat & wb_sel_i[0] & bb_on;
	wire        go_rdat = go & ~wb_we_i & a_dat & (mode_r == MD_ASYNC);
	wire [31:0] sel_w   = ({12'h000, sel_r} & ~wmask) | (wb_dat_i & wmask);
	wire [31:0] gpio_w  = ({24'h000000, gpoe_r, gpo_r} & ~wmask) | (wb_dat_i & wmask);
	// RULE17 no charger until detection done
	wire        chg     = chg_det_i & chg_done_i;
	wire [31:0] stat_w  = {26'h0, ~port_write_strobe_n_r, st_r != BB_IDLE,
		bus_power_sense_o, chg, susp_r, usb_susp_req_i};

	logic [31:0] rd_mux;
	always_comb begin
		case (wb_adr_i)
			ADR_SEL:  rd_mux = {12'h000, sel_r};
			ADR_MODE: rd_mux = {30'h0, mode_r};
			ADR_PRE:  rd_mux = {18'h0, pre_r};
			ADR_GPIO: rd_mux = {20'h00000, cpg_s_r, gpoe_r, gpo_r};
			// Async reads see live pins, sync reads the sample taken at the last write
			ADR_DATA: rd_mux = {24'h000000, (mode_r == MD_SYNC) ? samp_r : port_s_r};
			ADR_DIR:  rd_mux = {24'h000000, dir_r};
			ADR_STAT: rd_mux = stat_w;
			default:  rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r  <= 1'b0;
			rdat_r <= 32'h00000000;
		end else begin
			ack_r  <= go;
			rdat_r <= go ? rd_mux : 32'h00000000;
		end
	end

	// RULE10 selection store
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_r  <= SEL_RST;
			mode_r <= MODE_RST;
			pre_r  <= PRE_RST;
			gpo_r  <= 4'h0;
			gpoe_r <= 4'h0;
			dir_r  <= 8'h00;
			dout_r <= 8'h00;
		end else if (wen) begin
			case (wb_adr_i)
				ADR_SEL:  sel_r <= sel_w[19:0];
				ADR_MODE: if (wb_sel_i[0]) mode_r <= wb_dat_i[1:0];
				ADR_PRE:  pre_r <= 14'((({18'h0, pre_r} & ~wmask) | (wb_dat_i & wmask)));
				ADR_GPIO: begin
					gpo_r  <= gpio_w[3:0];
					gpoe_r <= gpio_w[7:4];
				end
				ADR_DATA: if (wb_sel_i[0]) dout_r <= wb_dat_i[7:0];
				ADR_DIR:  if (wb_sel_i[0]) dir_r <= wb_dat_i[7:0];
				default:  ;
			endcase
		end
	end

	// Bit-bang sequencer; the bus stalls on the data register while busy
	wire [13:0] pace = (pre_r == 14'h0000) ? 14'h0001 : pre_r;
	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = (cnt_r == 14'h0000) ? 14'h0000 : cnt_r - 14'h0001;
		case (st_r)
			BB_IDLE: begin
				// RULE14 sample before drive
				if (go_wdat && mode_r == MD_SYNC) begin
					st_nxt  = BB_RD;
					cnt_nxt = STB_CYC - 14'h0001;
				// RULE12 async write
				end else if (go_wdat) begin
					st_nxt  = BB_WR;
					cnt_nxt = STB_CYC - 14'h0001;
				end else if (go_rdat) begin
					st_nxt  = BB_RD;
					cnt_nxt = STB_CYC - 14'h0001;
				end
			end
			BB_RD: if (cnt_r == 14'h0000) begin
				st_nxt  = wr_pend_r ? BB_WR : BB_IDLE;
				cnt_nxt = STB_CYC - 14'h0001;
			end
			BB_WR: if (cnt_r == 14'h0000) begin
				st_nxt  = BB_PACE;
				cnt_nxt = pace - 14'h0001;
			end
			BB_PACE: if (cnt_r == 14'h0000) st_nxt = BB_IDLE;
			default: st_nxt = BB_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r      <= BB_IDLE;
			cnt_r     <= 14'h0000;
			wr_pend_r <= 1'b0;
			samp_r    <= 8'h00;
			drive_r   <= 8'h00;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
			if (st_r == BB_IDLE) wr_pend_r <= go_wdat;
			// RULE14 capture on write
			if (go_wdat && mode_r == MD_SYNC) samp_r <= port_s_r;
			if (st_r != BB_WR && st_nxt == BB_WR) drive_r <= (st_r == BB_IDLE) ? wb_dat_i[7:0] : dout_r;
		end
	end

	// Suspend, frame toggle, activity stretch
	always_comb begin
		vbus    = 1'b1;
		inhibit = 1'b0;
		for (int i = 0; i < 4; i++) begin
			// RULE7 sense input
			if (sel_r[5*i +: 5] == FN_VBUS) vbus = cpg_s_r[i];
			// RULE9 keep awake
			if (sel_r[5*i +: 5] == FN_AWAKE && !cpg_s_r[i]) inhibit = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			susp_r <= 1'b0;
			sof_r  <= 1'b0;
			txl_r  <= 8'h00;
			rxl_r  <= 8'h00;
			bus_power_sense_o <= 1'b1;
		end else begin
			susp_r <= usb_susp_req_i & ~inhibit;
			// RULE8 toggle per frame
			if (usb_sof_i) sof_r <= ~sof_r;
			// RULE16 stretch activity
			txl_r <= usb_tx_act_i ? LED_CYC : (txl_r == 8'h00 ? 8'h00 : txl_r - 8'h01);
			rxl_r <= usb_rx_act_i ? LED_CYC : (rxl_r == 8'h00 ? 8'h00 : rxl_r - 8'h01);
			bus_power_sense_o <= vbus;
		end
	end

	// RULE2 clocks from an accumulator, held at zero in suspend
	always_ff @(posedge clk_i) begin
		if (rst_i || susp_r) begin
			nco_r   <= 32'h00000000;
			ckf_d_r <= 1'b0;
			ckm_r   <= 1'b0;
			ckm_d_r <= 1'b0;
			cks_r   <= 1'b0;
		end else begin
			nco_r   <= nco_r + NCO_INC;
			ckf_d_r <= nco_r[31];
			ckm_d_r <= ckm_r;
			if (nco_r[31] && !ckf_d_r) ckm_r <= ~ckm_r;
			if (ckm_r && !ckm_d_r) cks_r <= ~cks_r;
		end
	end

	// RULE10 per-pin function select
	for (genvar g = 0; g < 4; g++) begin : g_pin
		wire [4:0] fn = sel_r[5*g +: 5];
		logic      p, o;
		always_comb begin
			p = 1'b0;
			o = 1'b1;
			case (fn)
				// RULE15 fixed options
				FN_TRI:   o = 1'b0;
				FN_ONE:   p = 1'b1;
				FN_ZERO:  p = 1'b0;
				FN_LDEN:  p = line_driver_enable_i;
				FN_PSW:   p = ~usb_cfg_i | susp_r;
				// RULE16 active-low activity
				FN_TXLED: p = txl_r == 8'h00;
				FN_RXLED: p = rxl_r == 8'h00;
				FN_ANLED: p = (txl_r == 8'h00) & (rxl_r == 8'h00);
				// RULE1 sleep indicator
				FN_SLEEP: p = ~susp_r;
				FN_CKF:   p = nco_r[31];
				FN_CKM:   p = ckm_r;
				FN_CKS:   p = cks_r;
				// RULE3 register GPIO
				FN_GPIO: begin
					p = gpo_r[g];
					o = gpoe_r[g];
				end
				// RULE4 charger, RULE5 complement
				FN_CHG:   p = chg;
				FN_CHGN:  p = ~chg;
				// RULE6 internal strobes
				FN_WRS:   p = port_write_strobe_n_r;
				FN_RDS:   p = port_read_strobe_n_r;
				FN_SOF:   p = sof_r;
				default:  o = 1'b0;
			endcase
		end
		assign pin_nxt[g] = p;
		assign oe_nxt[g]  = o;
	end

	// Output flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			config_pin_group_o    <= 4'h0;
			config_pin_group_oe_o <= 4'h0;
			port_o                <= 8'h00;
			port_oe_o             <= 8'h00;
			uart_in_o             <= 8'hFF;
			usb_suspend_o         <= 1'b0;
			port_write_strobe_n_r <= 1'b1;
			port_read_strobe_n_r  <= 1'b1;
		end else begin
			config_pin_group_o    <= pin_nxt;
			config_pin_group_oe_o <= oe_nxt;
			// RULE11 port replaces UART lines
			port_o                <= bb_on ? drive_r : uart_out_i;
			port_oe_o             <= bb_on ? dir_r : uart_oe_i;
			uart_in_o             <= bb_on ? 8'hFF : port_s_r;
			usb_suspend_o         <= susp_r;
			// RULE13 strobe each access except sync-mode reads
			port_write_strobe_n_r <= st_r != BB_WR;
			port_read_strobe_n_r  <= st_r != BB_RD;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_SLEEP: assert property ($stable(sel_r) && sel_r[19:15] == FN_SLEEP |=> // RULE1
		config_pin_group_o[3] == !$past(susp_r)) else $error("sleep pin wrong");
	AST_CLKSTOP: assert property (susp_r |=> nco_r == 32'h00000000 && !ckm_r && !cks_r) // RULE2
		else $error("clock runs in suspend");
	AST_CHGN: assert property ($stable(sel_r) && sel_r[9:5] == FN_CHGN |=> // RULE5
		config_pin_group_o[1] == !$past(chg_det_i & chg_done_i)) else $error("charger complement wrong");
	AST_SOF: assert property (usb_sof_i |=> sof_r != $past(sof_r)) // RULE8
		else $error("frame toggle missed");
	AST_AWAKE: assert property (inhibit |=> !susp_r ##1 !usb_suspend_o) // RULE9
		else $error("suspend despite keep awake");
	AST_WRLEN: assert property ($fell(port_write_strobe_n_r) |-> // RULE13
		!port_write_strobe_n_r[*4] ##1 port_write_strobe_n_r) else $error("write strobe width");
	AST_SYNC: assert property (go_wdat && mode_r == MD_SYNC |=> st_r == BB_RD ##4 st_r == BB_WR) // RULE14
		else $error("sync sample order");
	AST_TRI: assert property ($stable(sel_r) && sel_r[14:10] == FN_TRI |=> !config_pin_group_oe_o[2]) // RULE15
		else $error("tristate pin driven");
	AST_ACK: assert property (ack_r |=> !ack_r) // RULE10
		else $error("ack longer than one cycle");
endmodule : cbm_top

// ### dv/cbm_pin_model.sv
// Pins outside the block: pull-ups, optional external drivers, strobe latch.
// Assumes the port write strobe is routed to configurable pin 0.
`timescale 1ns/1ps
module cbm_pin_model (
	// Block side
	input  wire logic [3:0] cfg_o_i,
	input  wire logic [3:0] cfg_oe_i,
	input  wire logic [7:0] port_o_i,
	input  wire logic [7:0] port_oe_i,
	// Bench side
	input  wire logic [3:0] cfg_ext_i,
	input  wire logic [3:0] cfg_ext_en_i,
	input  wire logic [7:0] port_ext_i,
	// Wire levels
	output logic [3:0]      cfg_wire_o,
	output logic [7:0]      port_wire_o,
	output logic [7:0]      cap_o
);
	// Undriven configurable pins settle at the pull-up level, never at a stale value; port pins follow the bench value
	assign cfg_wire_o  = (cfg_oe_i & cfg_o_i) | (~cfg_oe_i & cfg_ext_en_i & cfg_ext_i) | (~cfg_oe_i & ~cfg_ext_en_i);
	assign port_wire_o = (port_oe_i & port_o_i) | (~port_oe_i & port_ext_i);
	always_ff @(posedge cfg_wire_o[0]) cap_o <= port_wire_o;
endmodule : cbm_pin_model

// ### dv/testbench.sv
// Self-checking bench for the pin multiplexer and bit-bang port.
// Assumes the pin model stands on the pins and Wishbone answers in bounded time.
`timescale 1ns/1ps
module testbench;
	import cbm_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0, rd;
	logic        susp = 1'b0, sof = 1'b0, txa = 1'b0, rxa = 1'b0, det = 1'b0, done = 1'b0, lde = 1'b1;
	logic        cfgd = 1'b1;
	logic [7:0]  uo = 8'h00, uoe = 8'h00;
	logic [3:0]  cext = 4'h0, cen = 4'h0;
	logic [7:0]  pext = 8'h00;
	wire logic   ack, susp_o, vbus_o;
	wire [31:0]  rdat;
	wire [7:0]   uin, po, poe, pw, cap;
	wire [3:0]   co, coe, cw;
	int          n_errors = 0, checks = 0;

	always #2 clk_i = ~clk_i;

	cbm_top cbm_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
		.usb_susp_req_i(susp), .usb_sof_i(sof), .usb_tx_act_i(txa), .usb_rx_act_i(rxa), .usb_cfg_i(cfgd),
		.chg_det_i(det), .chg_done_i(done), .line_driver_enable_i(lde), .usb_suspend_o(susp_o),
		.bus_power_sense_o(vbus_o), .uart_out_i(uo), .uart_oe_i(uoe), .uart_in_o(uin), .port_i(pw),
		.port_o(po), .port_oe_o(poe), .config_pin_group_i(cw), .config_pin_group_o(co),
		.config_pin_group_oe_o(coe));

	cbm_pin_model cbm_pin_model_inst (.cfg_o_i(co), .cfg_oe_i(coe), .port_o_i(po), .port_oe_i(poe),
		.cfg_ext_i(cext), .cfg_ext_en_i(cen), .port_ext_i(pext), .cfg_wire_o(cw), .port_wire_o(pw), .cap_o(cap));

	task automatic test_done;
		if (n_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	task automatic stuck;
		n_errors++;
		$display("ERROR %0t wait ran out", $time);
		test_done();
	endtask : stuck

	// Request held until the edge that samples ack; read data taken there
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 1000);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (k >= 1000)
			stuck();
	endtask : wb

	task automatic sel4(input logic [4:0] f0, input logic [4:0] f1, input logic [4:0] f2, input logic [4:0] f3);
		wb(1'b1, ADR_SEL, {12'h000, f3, f2, f1, f0});
		tick(4);
	endtask : sel4

	task automatic wait_pin(input int i, input logic v, output int k);
		k = 0;
		while (cw[i] !== v && k < 2000) begin
			@(posedge clk_i);
			k++;
		end
		if (k >= 2000)
			stuck();
	endtask : wait_pin

	// Rising edges on pin 0 during one microsecond
	task automatic edges(output int n);
		logic p;
		n = 0;
		p = co[0];
		repeat (250) begin
			@(posedge clk_i);
			if (co[0] === 1'b1 && p === 1'b0)
				n++;
			p = co[0];
		end
	endtask : edges

	task automatic t_reset;
		wb(1'b0, ADR_SEL, 32'h0);
		chk(rd, {12'h000, SEL_RST});
		wb(1'b0, ADR_PRE, 32'h0);
		chk(rd, {18'h0, PRE_RST});
		chk(co, 4'hF);
		chk(coe, 4'hF);
		chk(vbus_o, 1'b1);
	endtask : t_reset

	task automatic t_const;
		sel4(FN_ONE, FN_ZERO, FN_TRI, FN_SLEEP);
		chk(coe, 4'hB);
		chk(co[1:0], 2'b01);
		susp <= 1'b1;
		tick(6);
		chk(co[3], 1'b0);
		chk(susp_o, 1'b1);
		susp <= 1'b0;
		tick(6);
		chk(co[3], 1'b1);
	endtask : t_const

	task automatic t_chg;
		det <= 1'b1;
		sel4(FN_CHG, FN_CHGN, FN_TRI, FN_TRI);
		chk(co[1:0], 2'b10);
		done <= 1'b1;
		tick(4);
		chk(co[1:0], 2'b01);
		det <= 1'b0;
		tick(4);
		chk(co[1:0], 2'b10);
	endtask : t_chg

	task automatic t_sof;
		logic v;
		sel4(FN_SOF, FN_TRI, FN_TRI, FN_TRI);
		v = co[0];
		for (int i = 1; i <= 3; i++) begin
			sof <= 1'b1;
			tick(1);
			sof <= 1'b0;
			tick(4);
			chk(co[0], v ^ i[0]);
		end
	endtask : t_sof

	task automatic t_clk;
		int n;
		int e;
		for (int k = 0; k < 3; k++) begin
			sel4(FN_CKF + 5'(k), FN_TRI, FN_TRI, FN_TRI);
			edges(n);
			e = 24 >> k;
			chk(32'(n >= e - 1 && n <= e + 1), 32'h1);
		end
		susp <= 1'b1;
		tick(6);
		edges(n);
		chk(n, 32'h0);
		susp <= 1'b0;
	endtask : t_clk

	task automatic t_led;
		sel4(FN_TXLED, FN_RXLED, FN_ANLED, FN_TRI);
		txa <= 1'b1;
		tick(1);
		txa <= 1'b0;
		tick(4);
		chk(co[2:0], 3'b010);
		tick(300);
		chk(co[2:0], 3'b111);
		rxa <= 1'b1;
		tick(1);
		rxa <= 1'b0;
		tick(4);
		chk(co[2:0], 3'b001);
		tick(300);
	endtask : t_led

	task automatic t_gpio;
		sel4(FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO);
		wb(1'b1, ADR_GPIO, 32'hF5);
		tick(4);
		chk(co, 4'h5);
		chk(coe, 4'hF);
		wb(1'b1, ADR_GPIO, 32'h0);
		cext <= 4'hA;
		cen <= 4'hF;
		tick(6);
		wb(1'b0, ADR_GPIO, 32'h0);
		chk(rd[11:8], 4'hA);
		chk(coe, 4'h0);
	endtask : t_gpio

	task automatic t_sense;
		sel4(FN_VBUS, FN_AWAKE, FN_TRI, FN_TRI);
		cext <= 4'h0;
		cen <= 4'h3;
		susp <= 1'b1;
		tick(6);
		chk(vbus_o, 1'b0);
		chk(susp_o, 1'b0);
		cext <= 4'h3;
		tick(6);
		chk(vbus_o, 1'b1);
		chk(susp_o, 1'b1);
		susp <= 1'b0;
		cen <= 4'h0;
		tick(6);
	endtask : t_sense

	task automatic t_async;
		int k;
		time t0;
		sel4(FN_WRS, FN_RDS, FN_TRI, FN_TRI);
		wb(1'b1, ADR_PRE, 32'd20);
		wb(1'b1, ADR_DIR, 32'hFF);
		wb(1'b1, ADR_MODE, 32'(MD_ASYNC));
		tick(4);
		chk(uin, 8'hFF);
		wb(1'b1, ADR_DATA, 32'hA5);
		wait_pin(0, 1'b0, k);
		chk(po, 8'hA5);
		chk(poe, 8'hFF);
		t0 = $time;
		wb(1'b1, ADR_DATA, 32'h3C);
		wait_pin(0, 1'b0, k);
		chk(32'(($time - t0) / 4 >= 24), 32'h1);
		wait_pin(0, 1'b1, k);
		tick(2);
		chk(cap, 8'h3C);
		fork
			wb(1'b0, ADR_DATA, 32'h0);
			wait_pin(1, 1'b0, k);
		join
		chk(rd[7:0], 8'h3C);
	endtask : t_async

	task automatic t_sync;
		wb(1'b1, ADR_DIR, 32'h0);
		wb(1'b1, ADR_MODE, 32'(MD_SYNC));
		pext <= 8'h5A;
		tick(8);
		wb(1'b1, ADR_DATA, 32'h0);
		pext <= 8'hC3;
		tick(40);
		wb(1'b0, ADR_DATA, 32'h0);
		chk(rd[7:0], 8'h5A);
		wb(1'b1, ADR_DATA, 32'h0);
		tick(40);
		wb(1'b0, ADR_DATA, 32'h0);
		chk(rd[7:0], 8'hC3);
		wb(1'b1, ADR_MODE, 32'h0);
	endtask : t_sync

	// Power switch and line driver pins, status word, UART pass-through
	task automatic t_misc;
		sel4(FN_PSW, FN_LDEN, FN_TRI, FN_TRI);
		chk(co[1:0], 2'b10);
		lde <= 1'b0;
		cfgd <= 1'b0;
		tick(4);
		chk(co[1:0], 2'b01);
		cfgd <= 1'b1;
		susp <= 1'b1;
		tick(6);
		chk(co[0], 1'b1);
		wb(1'b0, ADR_STAT, 32'h0);
		chk(rd, 32'h0000000B);
		susp <= 1'b0;
		uo <= 8'h96;
		uoe <= 8'hF0;
		tick(6);
		chk(po, 8'h96);
		chk(poe, 8'hF0);
		chk(uin, 8'h93);
	endtask : t_misc

	initial begin
		tick(16);
		rst_i <= 1'b0;
		tick(4);
		t_reset();
		t_const();
		t_chg();
		t_sof();
		t_clk();
		t_led();
		t_gpio();
		t_sense();
		t_async();
		t_sync();
		t_misc();
		test_done();
	end
endmodule : testbench
